// *** inc/pai_pkg.sv ***
// pai_pkg: constants and carrier types for the two-axis pulse input handling block
// assumes a single 100 MHz clock domain; all inputs already synchronous
package pai_pkg;

	// ----------------------------------------
	// mode select switch codes {switch bit one, switch bit two}
	// ----------------------------------------
	localparam logic [1:0] PAI_MODE_AXIS_BOTH = 2'h0;
	localparam logic [1:0] PAI_MODE_AXIS_A_FB = 2'h1;
	localparam logic [1:0] PAI_MODE_AXIS_B_FB = 2'h2;
	localparam logic [1:0] PAI_MODE_STATION   = 2'h3;

	// ----------------------------------------
	// parameter field values
	// ----------------------------------------
	localparam logic       PAI_OC_PULSE       = 1'h0;
	localparam logic       PAI_OC_DIGITAL     = 1'h1;
	localparam logic [1:0] PAI_FORM_QUAD4     = 2'h0;
	localparam logic [1:0] PAI_FORM_PULSE_DIR = 2'h1;
	localparam logic [1:0] PAI_FORM_CW_CCW    = 2'h2;
	localparam logic [1:0] PAI_FORM_QUAD1     = 2'h3;
	localparam int         PAI_NUM_AXES       = 2;
	localparam int         PAI_AXIS_A         = 0;
	localparam int         PAI_AXIS_B         = 1;
	localparam int         PAI_CNT_W          = 32;
	localparam logic [31:0] PAI_CNT_RESET     = 32'h0;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic alarm;
		logic ready;
		logic in_position;
		logic home_marker;
		logic upper_limit;
		logic lower_limit;
		logic prox_dog;
		logic fb_a;
		logic fb_b;
	} pai_axis_in_t;

	typedef struct packed {
		logic       driver_input_enable;
		logic [1:0] feedback_form;
		logic       oc_output_function;
		logic       dog_enable;
		logic       homing;
	} pai_axis_cfg_t;

	typedef struct packed {
		logic alarm;
		logic ready;
		logic in_position;
		logic home_seen;
		logic upper_limit;
		logic lower_limit;
		logic prox_dog;
	} pai_axis_stat_t;

endpackage : pai_pkg

// *** logic/pai_axis_input.sv ***
// pai_axis_input: per-axis input handling, pulse gating and feedback counting
// assumes sensor and driver inputs are clean logic levels, synchronous to i_clock
//
// How it works
// - a driver alarm latches the axis alarm and halts that axis's command pulses.
// - no command pulse leaves an axis until its driver reports ready.
// - feedback pulses are counted only when the mode switch puts that connector on feedback.
// - the feedback decoder form is chosen by a per-axis parameter.
// - alarm, ready and in-position are used only when their enable parameter is set.
// - the home marker is sampled and latched during a home return.
// - upper and lower travel limits are passed on to the motion controller.
// - the proximity dog acts only when the controller enables it.
// - in-position is forwarded but never gates pulse output.
// - in station mode a parameter routes the open-collector terminals to pulse or outputs.
// - pulse output starts only once the controller link is established.
`timescale 1ns/1ps
`default_nettype none

module pai_axis_input (
	// clock and reset
	input  wire logic                                      i_clock,
	input  wire logic                                      i_arst_n,
	// mode and link
	input  wire logic [1:0]                                i_mode_select_switch,
	input  wire logic                                      i_link_up,
	input  wire logic [pai_pkg::PAI_NUM_AXES-1:0]          i_alarm_reset,
	// per-axis sensors and configuration
	input  wire pai_pkg::pai_axis_in_t  [pai_pkg::PAI_NUM_AXES-1:0] i_axis,
	input  wire pai_pkg::pai_axis_cfg_t [pai_pkg::PAI_NUM_AXES-1:0] i_cfg,
	// command pulse request and general outputs
	input  wire logic [pai_pkg::PAI_NUM_AXES-1:0]          i_cmd_pulse,
	input  wire logic [pai_pkg::PAI_NUM_AXES-1:0]          i_general_output_four,
	input  wire logic [pai_pkg::PAI_NUM_AXES-1:0]          i_general_output_five,
	// outputs
	output logic [pai_pkg::PAI_NUM_AXES-1:0]               o_forward_pulse_out,
	output logic [pai_pkg::PAI_NUM_AXES-1:0]               o_oc_term_one,
	output logic [pai_pkg::PAI_NUM_AXES-1:0]               o_oc_term_two,
	output pai_pkg::pai_axis_stat_t [pai_pkg::PAI_NUM_AXES-1:0] o_status,
	output logic [pai_pkg::PAI_NUM_AXES-1:0][pai_pkg::PAI_CNT_W-1:0] o_fb_count
);
	import pai_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// step of feedback counter for a given form: +1, -1 or 0
	function automatic logic [PAI_CNT_W-1:0] pai_fb_step(input logic [1:0] form,
		input logic a, input logic b, input logic pa, input logic pb);
		logic ra;
		logic fa;
		logic step_up;
		logic step_dn;
		ra = a & ~pa;
		fa = ~a & pa;
		step_up = 1'b0;
		step_dn = 1'b0;
		unique case (form)
			PAI_FORM_QUAD4: begin
				step_up = ((a ^ pa) & (a ^ b)) | ((b ^ pb) & ~(a ^ b));
				step_dn = ((a ^ pa) & ~(a ^ b)) | ((b ^ pb) & (a ^ b));
			end
			PAI_FORM_PULSE_DIR: begin
				step_up = ra & ~b;
				step_dn = ra & b;
			end
			PAI_FORM_CW_CCW: begin
				step_up = ra;
				step_dn = b & ~pb;
			end
			PAI_FORM_QUAD1: begin
				step_up = ra & ~b;
				step_dn = fa & ~b;
			end
		endcase
		if (step_up && !step_dn)
			return {{(PAI_CNT_W-1){1'b0}}, 1'b1};
		else if (step_dn && !step_up)
			return {PAI_CNT_W{1'b1}};
		else
			return {PAI_CNT_W{1'b0}};
	endfunction : pai_fb_step

	// ----------------------------------------
	// axis logic
	// ----------------------------------------
	wire logic station = (i_mode_select_switch == PAI_MODE_STATION);
	// connector of axis A carries its own feedback in axis A feedback mode, and likewise for B
	wire logic [PAI_NUM_AXES-1:0] fb_sel;
	assign fb_sel[PAI_AXIS_A] = (i_mode_select_switch == PAI_MODE_AXIS_A_FB);
	assign fb_sel[PAI_AXIS_B] = (i_mode_select_switch == PAI_MODE_AXIS_B_FB);

	logic [PAI_NUM_AXES-1:0] alarm_r;
	logic [PAI_NUM_AXES-1:0] pa_r;
	logic [PAI_NUM_AXES-1:0] pb_r;
	logic [PAI_NUM_AXES-1:0] primed_r;

	genvar g;
	for (g = 0; g < PAI_NUM_AXES; g++) begin : g_axis
		wire logic drv_en   = i_cfg[g].driver_input_enable;
		wire logic alm_in   = drv_en & i_axis[g].alarm;
		wire logic rdy_ok   = ~drv_en | i_axis[g].ready;
		wire logic inpos_in = drv_en & i_axis[g].in_position;
		wire logic dog_in   = i_cfg[g].dog_enable & i_axis[g].prox_dog;
		// pulse gate; in-position not used here
		wire logic gate_ok  = i_link_up & rdy_ok & ~alarm_r[g] & ~alm_in;
		wire logic pulse_nxt = gate_ok & i_cmd_pulse[g];
		wire logic oc_dig   = station & (i_cfg[g].oc_output_function == PAI_OC_DIGITAL);
		wire logic [PAI_CNT_W-1:0] step = pai_fb_step(i_cfg[g].feedback_form,
			i_axis[g].fb_a, i_axis[g].fb_b, pa_r[g], pb_r[g]);
		wire logic home_nxt = i_cfg[g].homing & (o_status[g].home_seen | i_axis[g].home_marker);

		always_ff @(posedge i_clock or negedge i_arst_n) begin
			if (!i_arst_n)
				alarm_r[g] <= 1'b0;
			else
				alarm_r[g] <= alm_in | (alarm_r[g] & ~i_alarm_reset[g]);
		end

		always_ff @(posedge i_clock or negedge i_arst_n) begin
			if (!i_arst_n) begin
				pa_r[g]                <= 1'b0;
				pb_r[g]                <= 1'b0;
				primed_r[g]            <= 1'b0;
				o_forward_pulse_out[g] <= 1'b0;
				o_oc_term_one[g]       <= 1'b0;
				o_oc_term_two[g]       <= 1'b0;
				o_status[g]            <= '0;
				o_fb_count[g]          <= PAI_CNT_RESET;
			end else begin
				pa_r[g]                <= i_axis[g].fb_a;
				pb_r[g]                <= i_axis[g].fb_b;
				primed_r[g]            <= 1'b1;
				o_forward_pulse_out[g] <= pulse_nxt;
				o_oc_term_one[g]       <= oc_dig ? i_general_output_four[g] : pulse_nxt;
				o_oc_term_two[g]       <= oc_dig ? i_general_output_five[g] : 1'b0;
				o_status[g].alarm       <= alm_in | (alarm_r[g] & ~i_alarm_reset[g]);
				o_status[g].ready       <= drv_en & i_axis[g].ready;
				o_status[g].in_position <= inpos_in;
				o_status[g].home_seen   <= home_nxt;
				o_status[g].upper_limit <= i_axis[g].upper_limit;
				o_status[g].lower_limit <= i_axis[g].lower_limit;
				o_status[g].prox_dog    <= dog_in;
				// feedback count
				// first sample after reset only primes the edge detector, no false count
				if (fb_sel[g] && primed_r[g])
					o_fb_count[g] <= o_fb_count[g] + step;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_alarm_halts;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_cfg[0].driver_input_enable && i_axis[0].alarm) |=> !o_forward_pulse_out[0];
	endproperty
	a_alarm_halts: assert property (p_alarm_halts) else $error("pulse during alarm");

	property p_alarm_sticky;
		@(posedge i_clock) disable iff (!i_arst_n)
		(o_status[0].alarm && !i_alarm_reset[0]) |=> o_status[0].alarm;
	endproperty
	a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm dropped");

	property p_ready_gate;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_cfg[1].driver_input_enable && !i_axis[1].ready) |=> !o_forward_pulse_out[1];
	endproperty
	a_ready_gate: assert property (p_ready_gate) else $error("pulse before ready");

	property p_fb_hold;
		@(posedge i_clock) disable iff (!i_arst_n)
		!fb_sel[0] |=> $stable(o_fb_count[0]);
	endproperty
	a_fb_hold: assert property (p_fb_hold) else $error("count without feedback mode");

	property p_fb_count;
		@(posedge i_clock) disable iff (!i_arst_n)
		(fb_sel[1] && primed_r[1] && i_cfg[1].feedback_form == PAI_FORM_CW_CCW
			&& !i_axis[1].fb_b && !pb_r[1] && i_axis[1].fb_a && !pa_r[1])
		|=> o_fb_count[1] == $past(o_fb_count[1]) + 32'h1;
	endproperty
	a_fb_count: assert property (p_fb_count) else $error("cw pulse not counted");

	property p_drv_disabled;
		@(posedge i_clock) disable iff (!i_arst_n)
		!i_cfg[0].driver_input_enable |=> !o_status[0].in_position && !o_status[0].ready;
	endproperty
	a_drv_disabled: assert property (p_drv_disabled) else $error("driver input used");

	property p_home;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_cfg[0].homing && i_axis[0].home_marker) |=> o_status[0].home_seen;
	endproperty
	a_home: assert property (p_home) else $error("home marker missed");

	property p_limits;
		@(posedge i_clock) disable iff (!i_arst_n)
		1'b1 |=> o_status[1].upper_limit == $past(i_axis[1].upper_limit)
			&& o_status[1].lower_limit == $past(i_axis[1].lower_limit);
	endproperty
	a_limits: assert property (p_limits) else $error("limit not forwarded");

	property p_dog;
		@(posedge i_clock) disable iff (!i_arst_n)
		!i_cfg[1].dog_enable |=> !o_status[1].prox_dog;
	endproperty
	a_dog: assert property (p_dog) else $error("dog used while disabled");

	property p_oc_digital;
		@(posedge i_clock) disable iff (!i_arst_n)
		(station && i_cfg[0].oc_output_function == PAI_OC_DIGITAL)
		|=> o_oc_term_one[0] == $past(i_general_output_four[0]);
	endproperty
	a_oc_digital: assert property (p_oc_digital) else $error("oc routing wrong");

	property p_link;
		@(posedge i_clock) disable iff (!i_arst_n)
		!i_link_up |=> !o_forward_pulse_out[0] && !o_forward_pulse_out[1];
	endproperty
	a_link: assert property (p_link) else $error("pulse without link");

endmodule : pai_axis_input

`default_nettype wire

// *** tb/pai_servo_model.sv ***
// pai_servo_model: behavioural servo drivers for both axes
// assumes the bench clock and reset; faults and settling are requested by the bench
`timescale 1ns/1ps
`default_nettype none

module pai_servo_model #(
	parameter int BOOT = 20
) (
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_arst_n,
	// bench requests
	input  wire logic [1:0] i_fault,
	input  wire logic [1:0] i_settle,
	// driver outputs
	output logic      [1:0] o_alarm,
	output logic      [1:0] o_ready,
	output logic      [1:0] o_in_pos
);
	int boot_cnt;

	// ready only when able
	// a faulted or booting driver never claims ready
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			boot_cnt <= 0;
			o_alarm  <= 2'h0;
			o_ready  <= 2'h0;
			o_in_pos <= 2'h0;
		end else begin
			if (boot_cnt < BOOT) boot_cnt <= boot_cnt + 1;
			o_alarm  <= i_fault;
			o_ready  <= (boot_cnt >= BOOT) ? ~i_fault : 2'h0;
			o_in_pos <= i_settle & o_ready;
		end
	end
endmodule : pai_servo_model
`default_nettype wire

// *** tb/pulse_axis_input_handling_bench.sv ***
// pulse_axis_input_handling_bench: self-checking bench of pai_axis_input
// assumes pai_pkg and pai_servo_model; expectations are noted in a queue
`timescale 1ns/1ps
`default_nettype none

module pulse_axis_input_handling_bench;
	import pai_pkg::*;
	typedef struct packed {
		int                   due;
		logic [1:0]           pls;
		pai_axis_stat_t [1:0] st;
	} pai_note_t;
	logic                 clock = 1'b0, arst_n = 1'b0, link = 1'b0;
	logic [1:0]           mode = 2'h0, clr = 2'h0, cmd = 2'h0, gp4 = 2'h0, gp5 = 2'h0;
	logic [1:0]           fault = 2'h0, settle = 2'h0, alm, rdy, inpos, pls, t1, t2;
	logic [1:0]           e_alm = 2'h0, e_home = 2'h0;
	pai_axis_cfg_t [1:0]  cfg = {2{6'h20}};
	pai_axis_in_t [1:0]   sens = '0, axis;
	pai_axis_stat_t [1:0] st;
	logic [1:0][31:0]     cnt;
	int                   cyc = 0, error_cnt = 0, samples_checked = 0, ea = 0, eb = 0;
	pai_note_t            q[$];
	localparam logic [1:0] MD [6] = '{2'h1, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2};
	localparam logic [1:0] FM [6] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h3, 2'h2};
	localparam logic [7:0] SQ [6] = '{8'h88, 8'h88, 8'hb4, 8'h77, 8'hb4, 8'h88};
	localparam int DA [6] = '{2, 0, 4, -2, 1, 0};

	always #5 clock = ~clock;
	always @(posedge clock) cyc++;
	always_comb begin
		axis = sens;
		for (int a = 0; a < 2; a++) begin
			axis[a].alarm       = alm[a];
			axis[a].ready       = rdy[a];
			axis[a].in_position = inpos[a];
		end
	end

	pai_servo_model i_pai_servo_model (.i_clock(clock), .i_arst_n(arst_n), .i_fault(fault),
		.i_settle(settle), .o_alarm(alm), .o_ready(rdy), .o_in_pos(inpos));
	pai_axis_input i_pai_axis_input (.i_clock(clock), .i_arst_n(arst_n),
		.i_mode_select_switch(mode), .i_link_up(link), .i_alarm_reset(clr), .i_axis(axis),
		.i_cfg(cfg), .i_cmd_pulse(cmd), .i_general_output_four(gp4),
		.i_general_output_five(gp5), .o_forward_pulse_out(pls), .o_oc_term_one(t1),
		.o_oc_term_two(t2), .o_status(st), .o_fb_count(cnt));

	// ----------------------------------------
	// notes, compares and closing
	// ----------------------------------------
	task automatic cmp_vec(input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_vec

	task automatic cmp_stat(input logic [13:0] e, input logic [13:0] g);
		cmp_vec({18'h0, e}, {18'h0, g});
	endtask : cmp_stat

	// one cycle of stimulus; old latch gates the pulse, new latch shows in status
	task automatic step(input bit note);
		pai_note_t n;
		logic      en;
		n.due = cyc + 1;
		for (int a = 0; a < 2; a++) begin
			en        = cfg[a].driver_input_enable;
			n.pls[a]  = cmd[a] & link & (~en | rdy[a]) & ~(en & alm[a]) & ~e_alm[a];
			e_alm[a]  = (en & alm[a]) | (e_alm[a] & ~clr[a]);
			e_home[a] = cfg[a].homing & (sens[a].home_marker | e_home[a]);
			n.st[a]   = {e_alm[a], en & rdy[a], en & inpos[a], e_home[a],
				sens[a].upper_limit, sens[a].lower_limit, sens[a].prox_dog & cfg[a].dog_enable};
		end
		if (note) q.push_back(n);
		@(posedge clock);
		#1;
	endtask : step

	task automatic play(input logic [7:0] sq);
		for (int i = 3; i >= 0; i--) begin
			{sens[0].fb_a, sens[0].fb_b} = sq[2*i+:2];
			sens[1].fb_a = sens[0].fb_a;
			sens[1].fb_b = sens[0].fb_b;
			step(0);
		end
	endtask : play

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude

	always @(negedge clock) begin
		while (q.size() > 0 && q[0].due <= cyc) begin
			cmp_vec({30'h0, q[0].pls}, {30'h0, pls});
			cmp_stat(q[0].st, st);
			void'(q.pop_front());
		end
	end

	initial begin
		#200000;
		error_cnt++;
		conclude();
	end

	initial begin
		void'($urandom(4358));
		repeat (12) @(posedge clock);
		#1 arst_n = 1'b1;
		repeat (4) begin cmd = 2'($urandom); step(1); end
		link = 1'b1;
		repeat (30) begin cmd = 2'($urandom); step(1); end
		fault = 2'h1;
		repeat (4) begin cmd = 2'($urandom); step(1); end
		fault = 2'h0;
		repeat (3) begin cmd = 2'($urandom); step(1); end
		cmd = 2'h0; clr = 2'h1; step(1);
		clr = 2'h0; settle = 2'h3;
		repeat (6) begin cmd = 2'($urandom); step(1); end
		repeat (16) begin
			for (int a = 0; a < 2; a++) begin
				sens[a] = 9'($urandom) & 9'h03c;
				cfg[a]  = {4'h8, 2'($urandom)};
			end
			cmd = 2'($urandom);
			step(1);
		end
		cfg = '0; fault = 2'h3;
		repeat (6) begin cmd = 2'($urandom); step(1); end
		fault = 2'h0; cfg = {2{6'h20}}; sens = '0; clr = 2'h3;
		repeat (4) step(1);
		clr = 2'h0;
		for (int i = 0; i < 6; i++) begin
			mode = MD[i]; cfg[0].feedback_form = FM[i]; cfg[1].feedback_form = FM[i];
			step(0);
			play(SQ[i]);
			sens = '0;
			ea += DA[i]; eb += (i == 5) ? 2 : 0;
			repeat (3) step(0);
			cmp_vec(32'(ea), cnt[0]);
			cmp_vec(32'(eb), cnt[1]);
		end
		mode = PAI_MODE_STATION; cmd = 2'h3;
		repeat (3) step(0);
		cmp_vec({30'h0, cmd}, {30'h0, t1});
		cmp_vec(32'h0, {30'h0, t2});
		cfg[0].oc_output_function = 1'b1; cfg[1].oc_output_function = 1'b1;
		gp4 = 2'($urandom); gp5 = 2'($urandom);
		repeat (3) step(0);
		cmp_vec({30'h0, gp4}, {30'h0, t1});
		cmp_vec({30'h0, gp5}, {30'h0, t2});
		conclude();
	end
endmodule : pulse_axis_input_handling_bench
`default_nettype wire
